// *** emb_ctrl.sv ***
// external program and data memory bus control: strobes, multiplexed port, fetch select
`include "emb_map.svh"

// How it works
// R1: low address byte and data byte share port 0 during every external access.
// R2: as plain I/O, port 0 is open drain; ones float.
// R3: while carrying bus address or data, ports 0 and 2 drive ones strongly.
// R4: port 2 gives the high address on external fetches and 16-bit pointer moves.
// R5: on 8-bit indirect moves port 2 keeps showing its own output latch.
// R6: address latch strobe, active high, marks the low address on port 0.
// R7: address latch strobe runs at one sixth of the oscillator, except in the data transfer slot.
// R8: each external data access drops exactly one address latch strobe pulse.
// R9: program fetch strobe goes low twice per machine cycle from external code.
// R10: each external data access skips two program fetch strobe activations.
// R11: access select low fetches all code externally, 0000H to 1FFFH included.
// R12: access select high fetches internally up to 1FFFH, externally above it.
// R13: reset pin held low two machine cycles, oscillator running, resets the device.
// R14: data write strobe on port 3 bit 6, read strobe on bit 7, active low.
// R15: during verify, port 0 shows the code byte; outside pullups are needed.
// R16: during verify, the equipment supplies low address on port 1, high on port 2.
// R17: the bus reaches 64K bytes of code and a separate 64K bytes of data.
// R18: program fetch strobe stays high for fetches served from internal memory.
// R19: the outside latch captures the low address on the strobe's falling edge.
module emb_ctrl #(
  parameter int FIFO_DEPTH = 8,
  parameter int RST_HOLD_CLKS = `EMB_RST_CLKS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire emb_pkg::emb_op_t req_op,
  input wire logic req_ptr16,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_internal,
  input wire logic [7:0] p0_latch,
  input wire logic [7:0] high_port_output_latch,
  input wire logic [7:0] verify_code_byte,
  output logic [15:0] verify_addr,
  output logic core_rst,
  input wire logic external_access_select_n,
  input wire logic rst_pin_n,
  input wire logic verify_mode,
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic [7:0] port0_oe,
  input wire logic [7:0] port1_in,
  input wire logic [7:0] port2_in,
  output logic [7:0] port2_out,
  output logic [7:0] port2_oe,
  output logic addr_latch_strobe,
  output logic program_fetch_strobe_n,
  output logic data_wr_strobe_n_p36,
  output logic data_rd_strobe_n_p37
);
  import emb_pkg::*;

  localparam logic [4:0] HOLD_LAST = 5'(RST_HOLD_CLKS - 1);
  localparam int SYNC_W = 27;

  logic fifo_valid, fifo_pop;
  logic [`EMB_REQ_W-1:0] fifo_data;
  emb_op_t head_op;
  logic [15:0] head_addr;

  // pins pass two flops; only the second stage is read
  logic [SYNC_W-1:0] sync1_q, sync2_q;
  logic [7:0] p0_s, p1_s, hp_s;
  logic xsel_n_s, rstp_n_s, vfy_s;

  emb_state_t state_q, state_d;
  emb_op_t op_q, op_d;
  logic [2:0] phase_q, phase_d;
  logic slot_q, slot_d, ptr16_q, ptr16_d, ext_q, ext_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [4:0] rcnt_q, rcnt_d;
  logic core_rst_q, core_rst_d;
  logic ale_q, ale_d, fetch_n_q, fetch_n_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d;
  logic [7:0] p0_out_q, p0_out_d, p0_oe_q, p0_oe_d, hp_out_q, hp_out_d, hp_oe_q, hp_oe_d;
  logic rsp_valid_q, rsp_valid_d, rsp_int_q, rsp_int_d;
  logic [7:0] rsp_data_q, rsp_data_d;
  logic [15:0] vaddr_q, vaddr_d;
  logic bus_on, hi_addr;

  emb_fifo #(
    .WIDTH(`EMB_REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_op, req_ptr16, req_addr, req_wdata}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign head_op = emb_op_t'(fifo_data[`EMB_REQ_OP_POS +: 2]);
  assign head_addr = fifo_data[`EMB_REQ_ADDR_POS +: 16];
  assign {p0_s, p1_s, hp_s, xsel_n_s, rstp_n_s, vfy_s} = sync2_q;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {port0_in, port1_in, port2_in, external_access_select_n, rst_pin_n, verify_mode};
      sync2_q <= sync1_q;
    end
  end

  always_comb
  begin
    phase_d = (phase_q == `EMB_SLOT_LAST) ? 3'h0 : phase_q + 3'h1;
    slot_d = (phase_q == `EMB_SLOT_LAST) ? ~slot_q : slot_q;
    state_d = state_q;
    op_d = op_q;
    ptr16_d = ptr16_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    ext_d = ext_q;
    fifo_pop = 1'b0;
    // a slot lasts six clocks, so one strobe per slot gives the 1/6 rate
    if (phase_q == `EMB_SLOT_LAST)
    begin
      state_d = ST_IDLE;
      if (core_rst_q || vfy_s)
      begin
        state_d = ST_IDLE;
      end
      else if (state_q == ST_DADDR)
      begin
        state_d = ST_DXFER;
      end
      else if (fifo_valid && (head_op == OP_FETCH || slot_q))
      begin
        // data moves start only on a machine cycle boundary
        state_d = (head_op == OP_FETCH) ? ST_FETCH : ST_DADDR;
        fifo_pop = 1'b1;
        op_d = head_op;
        ptr16_d = fifo_data[`EMB_REQ_PTR_POS];
        addr_d = head_addr;
        wdata_d = fifo_data[`EMB_REQ_DATA_POS +: 8];
        ext_d = (head_op != OP_FETCH) || !xsel_n_s || (head_addr > `EMB_ROM_TOP); // R11 R12 R17
      end
    end
  end

  always_comb
  begin
    bus_on = (state_d == ST_FETCH && ext_d) || state_d == ST_DADDR || state_d == ST_DXFER;
    hi_addr = bus_on && (state_d == ST_FETCH || ptr16_d);
    ale_d = (phase_d < `EMB_ALE_CLKS) && state_d != ST_DXFER; // R6 R7 R8
    fetch_n_d = !(state_d == ST_FETCH && ext_d && phase_d >= `EMB_FETCH_STROBE_FIRST); // R9 R10 R18
    rd_n_d = !(state_d == ST_DXFER && op_d == OP_READ && phase_d >= `EMB_XFER_STROBE_FIRST); // R14
    wr_n_d = !(state_d == ST_DXFER && op_d == OP_WRITE && phase_d >= `EMB_XFER_STROBE_FIRST); // R14
    p0_out_d = p0_latch;
    p0_oe_d = ~p0_latch; // R2
    if (vfy_s)
    begin
      p0_out_d = verify_code_byte; // R15
      p0_oe_d = ~verify_code_byte;
    end
    if (state_d == ST_DADDR || (state_d == ST_FETCH && ext_d && phase_d < `EMB_FETCH_STROBE_FIRST))
    begin
      p0_out_d = addr_d[7:0]; // R1 R3
      p0_oe_d = `EMB_PORT_RST;
    end
    else if (state_d == ST_DXFER)
    begin
      p0_out_d = wdata_d; // R1
      p0_oe_d = (op_d == OP_WRITE) ? `EMB_PORT_RST : 8'h00;
    end
    else if (state_d == ST_FETCH && ext_d)
    begin
      p0_out_d = `EMB_PORT_RST;
      p0_oe_d = 8'h00;
    end
    // ones from the latch are left to the weak pullup; bus address is driven strongly
    hp_out_d = hi_addr ? addr_d[15:8] : high_port_output_latch; // R4 R5
    hp_oe_d = hi_addr ? `EMB_PORT_RST : ~high_port_output_latch; // R3
    rsp_valid_d = (phase_q == `EMB_SLOT_LAST) &&
                  (state_q == ST_FETCH || (state_q == ST_DXFER && op_q == OP_READ));
    rsp_data_d = (rsp_valid_d && ext_q) ? p0_s : 8'h00;
    rsp_int_d = rsp_valid_d && !ext_q;
    vaddr_d = vfy_s ? {hp_s, p1_s} : vaddr_q; // R16
    rcnt_d = rstp_n_s ? 5'h00 : ((rcnt_q == HOLD_LAST) ? rcnt_q : rcnt_q + 5'h01);
    core_rst_d = !rstp_n_s && (rcnt_q == HOLD_LAST || core_rst_q); // R13
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_FETCH;
      // start on the last phase of slot 1 so the first edge opens a full-width strobe in slot 0
      phase_q <= `EMB_SLOT_LAST;
      slot_q <= 1'b1;
      ptr16_q <= 1'b0;
      ext_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      rcnt_q <= 5'h00;
      core_rst_q <= 1'b0;
      ale_q <= 1'b0;
      fetch_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      p0_out_q <= `EMB_PORT_RST;
      p0_oe_q <= 8'h00;
      hp_out_q <= `EMB_PORT_RST;
      hp_oe_q <= 8'h00;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
      rsp_int_q <= 1'b0;
      vaddr_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      phase_q <= phase_d;
      slot_q <= slot_d;
      ptr16_q <= ptr16_d;
      ext_q <= ext_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rcnt_q <= rcnt_d;
      core_rst_q <= core_rst_d;
      ale_q <= ale_d;
      fetch_n_q <= fetch_n_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      p0_out_q <= p0_out_d;
      p0_oe_q <= p0_oe_d;
      hp_out_q <= hp_out_d;
      hp_oe_q <= hp_oe_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      rsp_int_q <= rsp_int_d;
      vaddr_q <= vaddr_d;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_internal = rsp_int_q;
  assign verify_addr = vaddr_q;
  assign core_rst = core_rst_q;
  assign port0_out = p0_out_q;
  assign port0_oe = p0_oe_q;
  assign port2_out = hp_out_q;
  assign port2_oe = hp_oe_q;
  assign addr_latch_strobe = ale_q;
  assign program_fetch_strobe_n = fetch_n_q;
  assign data_wr_strobe_n_p36 = wr_n_q;
  assign data_rd_strobe_n_p37 = rd_n_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  ale_width_a: assert property ($rose(ale_q) |-> ale_q [*2] ##1 !ale_q [*4] ##1 (ale_q || state_q == ST_DXFER)) // R7
    else $error("address strobe width or period wrong");
  ale_skip_a: assert property ((state_q == ST_DADDR && phase_q == 3'h0) |-> ale_q ##6 !ale_q ##6 ale_q) // R8
    else $error("data access did not drop exactly one address strobe");
  ale_addr_a: assert property ((ale_q && state_q == ST_DADDR) |-> (port0_out == addr_q[7:0] && &port0_oe)) // R6
    else $error("low address not on port 0 under strobe");
  fstrobe_twice_a: assert property ((state_q == ST_FETCH && ext_q && phase_q == 3'h3) |-> !fetch_n_q [*3] ##1 fetch_n_q) // R9
    else $error("fetch strobe shape wrong");
  fstrobe_skip_a: assert property ((state_q == ST_DADDR || state_q == ST_DXFER) |-> fetch_n_q) // R10
    else $error("fetch strobe during data access");
  fstrobe_int_a: assert property ((state_q == ST_FETCH && !ext_q) |-> fetch_n_q) // R18
    else $error("fetch strobe on internal fetch");
  ext_sel_a: assert property ((fifo_pop && head_op == OP_FETCH && !xsel_n_s) |=> ext_q) // R11
    else $error("access select low did not force external fetch");
  int_sel_a: assert property ((fifo_pop && head_op == OP_FETCH && xsel_n_s) |=> (ext_q == (addr_q > 16'h1FFF))) // R12
    else $error("internal fetch boundary wrong");
  hi_addr_a: assert property ((state_q == ST_DXFER && ptr16_q) |-> (port2_out == addr_q[15:8] && &port2_oe)) // R4
    else $error("high address missing on pointer move");
  hi_latch_a: assert property ((state_q == ST_DXFER && !ptr16_q) |-> port2_out == $past(high_port_output_latch)) // R5
    else $error("port 2 latch not shown on indirect move");
  wr_data_a: assert property ((!wr_n_q) |-> (port0_out == wdata_q && &port0_oe && state_q == ST_DXFER)) // R1
    else $error("write data not on port 0 under write strobe");
  rd_float_a: assert property ((!rd_n_q) |-> (port0_oe == 8'h00 && wr_n_q)) // R14
    else $error("port 0 driven during read strobe");
  open_drain_a: assert property ((state_q == ST_IDLE && !vfy_s) |-> (port0_oe == ~port0_out)) // R2
    else $error("port 0 not open drain as plain I/O");
  rst_hold_a: assert property ((!rstp_n_s && rcnt_q == HOLD_LAST) |=> core_rst_q) // R13
    else $error("reset pin not honoured after two machine cycles");

  ext_fetch_c: cover property (state_q == ST_FETCH && ext_q && rsp_valid_d);
  int_fetch_c: cover property (rsp_valid_q && rsp_internal);
  data_read_c: cover property ($rose(rd_n_q));
  data_write_c: cover property ($rose(wr_n_q) && ptr16_q);
endmodule

// *** emb_map.svh ***
// timing counts, field positions and reset values for the external memory bus control
`ifndef EMB_MAP_SVH
`define EMB_MAP_SVH

`define EMB_MCYCLE_CLKS 12
`define EMB_RST_MCYCLES 2
`define EMB_RST_CLKS (`EMB_RST_MCYCLES * `EMB_MCYCLE_CLKS)
`define EMB_SLOT_LAST 3'h5
`define EMB_ALE_CLKS 3'h2
`define EMB_FETCH_STROBE_FIRST 3'h3
`define EMB_XFER_STROBE_FIRST 3'h1
`define EMB_ROM_TOP 16'h1FFF
`define EMB_PORT_RST 8'hFF
`define EMB_REQ_OP_POS 25
`define EMB_REQ_PTR_POS 24
`define EMB_REQ_ADDR_POS 8
`define EMB_REQ_DATA_POS 0
`define EMB_REQ_W 27

`endif

// *** emb_pkg.sv ***
// types shared by the external memory bus control
package emb_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_FETCH = 2'h1,
    ST_DADDR = 2'h3,
    ST_DXFER = 2'h2
  } emb_state_t;

  typedef enum logic [1:0]
  {
    OP_FETCH = 2'h0,
    OP_READ = 2'h1,
    OP_WRITE = 2'h2
  } emb_op_t;
endpackage

// *** emb_fifo.sv ***
// request fifo with registered full and empty flags
module emb_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic in_ready_q, in_ready_d, out_valid_q, out_valid_d;
  logic push, pop;

  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = mem[rd_q];

  always_comb
  begin
    push = in_valid && in_ready_q;
    pop = out_valid_q && out_ready;
    wr_d = push ? ((wr_q == PTR_LAST) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == PTR_LAST) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop)
    begin
      cnt_d = cnt_q + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_d = cnt_q - 1'b1;
    end
    // full only blocks the source, so a stalled drain backs up into req_ready
    in_ready_d = (cnt_d != CNT_FULL);
    out_valid_d = (cnt_d != '0);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b0;
      out_valid_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      in_ready_q <= in_ready_d;
      out_valid_q <= out_valid_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

// *** emb_mem_model.sv ***
// external code and data memory behind an address latch, as seen from the bus pins
module emb_mem_model (
  input wire logic sys_clk,
  input wire logic [7:0] port0,
  input wire logic [7:0] port2,
  input wire logic ale,
  input wire logic fetch_n,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] drv,
  output logic drv_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] addr = 16'h0000;
  logic [7:0] mem [logic [15:0]];
  // the latch closes on the falling strobe, so port0 must still hold the low byte there
  always @(negedge ale) addr = {port2, port0};
  always @(posedge sys_clk) if (!wr_n) mem[addr] = port0;
  always @*
  begin
    drv_en = !fetch_n || !rd_n;
    if (!fetch_n) drv = addr[7:0] ^ addr[15:8] ^ 8'h5A;
    else drv = mem.exists(addr) ? mem[addr] : 8'h00;
  end
endmodule

// *** test_external_memory_bus_control.sv ***
// self-checking bench for the external memory bus control
module test_external_memory_bus_control;
  timeunit 1ns;
  timeprecision 1ns;
  import emb_pkg::*;
  typedef struct {logic [7:0] d; logic i;} emb_exp_t;
  logic sys_clk = 0, sys_rst = 1, req_valid = 0, req_ptr16 = 0, xsel_n = 0, rst_n = 1, vmode = 0;
  emb_op_t req_op = OP_FETCH;
  logic [15:0] req_addr = 16'h0000, verify_addr;
  logic [7:0] req_wdata = 8'h00, p0_latch = 8'h00, hp_latch = 8'h00, vbyte = 8'h00;
  logic [7:0] p1_in = 8'h00, hp_in = 8'h00, p0_wire, last_q = 8'h00, hp_wire, drv, rsp_data;
  logic [7:0] port0_out, port0_oe, port2_out, port2_oe;
  logic req_ready, rsp_valid, rsp_internal, core_rst, ale, pfs_n, wr_n, rd_n, drv_en;
  logic ale_d = 0, pfs_d = 1, rd_d = 1, wr_d = 1, seen = 0, mon_on = 0;
  emb_exp_t expq[$];
  emb_exp_t got_e;
  logic [7:0] dmem [logic [15:0]];
  int mismatches = 0, num_checks = 0, cyc = 0, gap = 0, n;
  int n_xf = 0, n_rd = 0, n_wr = 0, pfs_f = 0, gaps12 = 0, rd_f = 0, wr_f = 0;

  emb_ctrl #(.FIFO_DEPTH(8), .RST_HOLD_CLKS(4)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_ptr16(req_ptr16),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_internal(rsp_internal), .p0_latch(p0_latch), .high_port_output_latch(hp_latch),
    .verify_code_byte(vbyte), .verify_addr(verify_addr), .core_rst(core_rst),
    .external_access_select_n(xsel_n), .rst_pin_n(rst_n), .verify_mode(vmode),
    .port0_in(p0_wire), .port0_out(port0_out), .port0_oe(port0_oe), .port1_in(p1_in),
    .port2_in(hp_in), .port2_out(port2_out), .port2_oe(port2_oe), .addr_latch_strobe(ale),
    .program_fetch_strobe_n(pfs_n), .data_wr_strobe_n_p36(wr_n), .data_rd_strobe_n_p37(rd_n));
  emb_mem_model i_mem (.sys_clk(sys_clk), .port0(p0_wire), .port2(hp_wire), .ale(ale),
    .fetch_n(pfs_n), .rd_n(rd_n), .wr_n(wr_n), .drv(drv), .drv_en(drv_en));

  always #25 sys_clk = ~sys_clk;
  // undriven port0 bits show the inverse of the last level so a stale value cannot pass
  always @* for (int i = 0; i < 8; i++)
    p0_wire[i] = port0_oe[i] ? port0_out[i] : (drv_en ? drv[i] : ~last_q[i]);
  assign hp_wire = (port2_out & port2_oe) | ~port2_oe;

  task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(logic got, logic exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_count(int got, int exp);
    num_checks++;
    if (got != exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // reference model: code bytes, internal fetch choice, data memory, strobe counts
  task automatic expect_req(emb_op_t op, logic p16, logic [15:0] a, logic [7:0] w);
    emb_exp_t e;
    logic [15:0] da;
    da = p16 ? a : {hp_latch, a[7:0]};
    e.i = (op == OP_FETCH) && xsel_n && (a <= 16'h1FFF);
    e.d = 8'h00;
    if (op == OP_FETCH && !e.i) e.d = a[7:0] ^ a[15:8] ^ 8'h5A;
    if (op == OP_READ && dmem.exists(da)) e.d = dmem[da];
    if (op == OP_WRITE) dmem[da] = w;
    else expq.push_back(e);
    n_xf += (op == OP_FETCH && !e.i);
    n_rd += (op == OP_READ);
    n_wr += (op == OP_WRITE);
  endtask
  task automatic send(emb_op_t op, logic p16, logic [15:0] a, logic [7:0] w);
    int k;
    @(negedge sys_clk);
    req_valid = 1;
    req_op = op;
    req_ptr16 = p16;
    req_addr = a;
    req_wdata = w;
    k = 0;
    do @(posedge sys_clk); while (req_ready !== 1'b1 && ++k < 300);
    if (k < 300) expect_req(op, p16, a, w);
    else mismatches++;
  endtask
  task automatic drain;
    @(negedge sys_clk);
    req_valid = 0;
    n = 0;
    while (expq.size() != 0 && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (expq.size() != 0) mismatches++;
    repeat (30) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk)
  begin
    last_q <= p0_wire;
    cyc <= cyc + 1;
    if (cyc > 40000)
    begin
      mismatches++;
      test_done;
    end
    if (!sys_rst && mon_on)
    begin
      gap <= gap + 1;
      if (ale && !ale_d)
      begin
        if (seen && gap == 12) gaps12++;
        else if (seen) chk_count(gap, 6);
        seen <= 1;
        gap <= 1;
      end
      pfs_f += (!pfs_n && pfs_d);
      rd_f += (!rd_n && rd_d);
      wr_f += (!wr_n && wr_d);
      if (rsp_valid === 1'b1 && expq.size() == 0) chk_bit(1'b1, 1'b0);
      else if (rsp_valid === 1'b1)
      begin
        got_e = expq.pop_front();
        chk_byte(rsp_data, got_e.d);
        chk_bit(rsp_internal, got_e.i);
      end
    end
    ale_d <= ale;
    pfs_d <= pfs_n;
    rd_d <= rd_n;
    wr_d <= wr_n;
  end

  initial
  begin
    n = $urandom(99722);
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 0;
    mon_on = 1;
    for (int m = 0; m < 2; m++)
    begin
      @(negedge sys_clk);
      xsel_n = m;
      repeat (4) @(posedge sys_clk);
      for (int k = 0; k < 5; k++)
        send(OP_FETCH, 0, k == 0 ? 16'h0000 : k == 1 ? 16'h1FFF : k == 2 ? 16'h2000 : $urandom, 0);
      drain;
    end
    @(negedge sys_clk);
    xsel_n = 0;
    for (int k = 0; k < 4; k++)
    begin
      @(negedge sys_clk);
      hp_latch = $urandom;
      p0_latch = $urandom;
      req_addr = $urandom;
      send(OP_WRITE, 0, req_addr, $urandom);
      send(OP_READ, 1, {hp_latch, req_addr[7:0]}, 0);
      send(OP_FETCH, 0, $urandom, 0);
      send(OP_WRITE, 1, {hp_latch, ~req_addr[7:0]}, $urandom);
      send(OP_READ, 0, ~req_addr, 0);
      drain;
    end
    @(negedge sys_clk);
    rst_n = 0;
    repeat (10) @(posedge sys_clk);
    chk_bit(core_rst, 1'b1);
    chk_byte(port0_oe, ~p0_latch);
    n = 0;
    for (int k = 0; k < 12; k++)
    begin
      @(negedge sys_clk);
      req_valid = 1;
      req_op = OP_FETCH;
      req_addr = $urandom;
      @(posedge sys_clk);
      if (req_ready === 1'b1)
      begin
        n++;
        expect_req(OP_FETCH, 0, req_addr, 0);
      end
    end
    chk_count(n, 8);
    @(negedge sys_clk);
    req_valid = 0;
    rst_n = 1;
    drain;
    chk_count(pfs_f, n_xf);
    chk_count(gaps12, n_rd + n_wr);
    chk_count(rd_f, n_rd);
    chk_count(wr_f, n_wr);
    mon_on = 0;
    @(negedge sys_clk);
    vmode = 1;
    p1_in = $urandom;
    hp_in = $urandom;
    vbyte = $urandom;
    repeat (8) @(posedge sys_clk);
    chk_byte(verify_addr[7:0], p1_in);
    chk_byte(verify_addr[15:8], hp_in);
    chk_byte(port0_oe, ~vbyte);
    chk_byte(port0_out, vbyte);
    test_done;
  end
endmodule
